// File: rtl/spc_sys_ref_clock_ctrl.sv
// spc_sys_ref_clock_ctrl: apb register file and control around the system
// clock multiplier pll: lock detect, pump current, filter select,
// stability timer, calibration trigger and reference monitor gating.
// assumes: pll status inputs are synchronous to pclk; apb master.
`timescale 1ns/1ps
`default_nettype none
module spc_sys_ref_clock_ctrl
  import spc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES // clock cycles per millisecond
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic pfd_sample, // one phase detector decision
  input wire logic pfd_in_phase, // decision is in phase
  input wire logic [7:0] fb_div_n, // feedback divider value
  input wire logic cal_done, // calibration finished pulse
  output logic pll_enable, // pll enabled
  output logic [2:0] cp_current, // pump current, steps minus one
  output logic ext_filter, // external loop filter in use
  output logic [PERIOD_W-1:0] sys_period, // nominal period, fs
  output logic cal_start, // calibration start pulse
  output logic cal_busy, // calibration running
  output logic pll_locked, // lock detector result
  output logic sys_stable, // stability timer expired
  output logic ref_mon_en // input_reference_pins monitors on
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pll_config_reg;
  logic pll_enable_reg;
  logic [PERIOD_W-1:0] nominal_period_reg;
  logic [STAB_W-1:0] stability_timer_setting_reg;
  logic [7:0] cal_sync_control_reg;
  logic [7:0] irq_monitor_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] sys_ref_clock_status;
  logic [13:0] idx;
  logic wr_access;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_next;
  logic locked;
  logic expired;
  logic arm_next;
  logic arm_reg;
  logic pll_en_q;
  logic cal_busy_q;
  logic stable_q;

  // automatic pump current choice from the feedback divider
  function automatic logic [2:0] auto_cp(input logic [7:0] n);
    if (n < N_LOW) begin
      auto_cp = CP_CODE_HI;
    end else if (n < N_MID) begin
      auto_cp = CP_CODE_MID;
    end else begin
      auto_cp = CP_CODE_LO;
    end
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign idx = paddr[15:2];
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  // address map hit
  always_comb begin
    unique case (idx)
      IDX_PLL_CONFIG, IDX_PLL_ENABLE, IDX_PERIOD_0, IDX_PERIOD_1,
      IDX_PERIOD_2, IDX_STAB_0, IDX_STAB_1, IDX_STAB_2, IDX_CAL_SYNC,
      IDX_STATUS, IDX_IRQ_MON, IDX_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // status view of the block's own state
  always_comb begin
    sys_ref_clock_status = '0;
    sys_ref_clock_status[ST_LOCK_BIT] = locked;
    sys_ref_clock_status[ST_CAL_BIT] = cal_busy_q;
    sys_ref_clock_status[ST_STABLE_BIT] = expired;
  end

  // read data mux
  always_comb begin
    rd_next = '0;
    unique case (idx)
      IDX_PLL_CONFIG: rd_next[7:0] = pll_config_reg;
      IDX_PLL_ENABLE: rd_next[0] = pll_enable_reg;
      IDX_PERIOD_0: rd_next[7:0] = nominal_period_reg[7:0];
      IDX_PERIOD_1: rd_next[7:0] = nominal_period_reg[15:8];
      IDX_PERIOD_2: rd_next[4:0] = nominal_period_reg[20:16];
      IDX_STAB_0: rd_next[7:0] = stability_timer_setting_reg[7:0];
      IDX_STAB_1: rd_next[7:0] = stability_timer_setting_reg[15:8];
      IDX_STAB_2: rd_next[3:0] = stability_timer_setting_reg[19:16];
      IDX_CAL_SYNC: rd_next[7:0] = cal_sync_control_reg;
      IDX_STATUS: rd_next[7:0] = sys_ref_clock_status;
      IDX_IRQ_MON: rd_next[7:0] = irq_monitor_reg;
      IDX_IRQ_MASK: rd_next[7:0] = irq_mask_reg;
      default: rd_next = '0;
    endcase
  end

  // no wait state: answer prepared in setup, given in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (rd_setup) begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= (pwrite || !hit) ? 32'h0 : rd_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // software-written settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_config_reg <= PLL_CONFIG_RST;
      pll_enable_reg <= 1'b0;
      nominal_period_reg <= '0;
      stability_timer_setting_reg <= '0;
      irq_mask_reg <= BYTE_RST;
    end else if (wr_access && !pslverr) begin
      unique case (idx)
        IDX_PLL_CONFIG: pll_config_reg <= pwdata[7:0];
        IDX_PLL_ENABLE: pll_enable_reg <= pwdata[0];
        IDX_PERIOD_0: nominal_period_reg[7:0] <= pwdata[7:0];
        IDX_PERIOD_1: nominal_period_reg[15:8] <= pwdata[7:0];
        IDX_PERIOD_2: nominal_period_reg[20:16] <= pwdata[4:0];
        IDX_STAB_0: stability_timer_setting_reg[7:0] <= pwdata[7:0];
        IDX_STAB_1: stability_timer_setting_reg[15:8] <= pwdata[7:0];
        IDX_STAB_2: stability_timer_setting_reg[19:16] <= pwdata[3:0];
        IDX_IRQ_MASK: irq_mask_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // calibration trigger
  // ----------------------------------------------------------------
  // bit 0 stored as written; a one-to-zero write starts calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_sync_control_reg <= BYTE_RST;
      cal_start <= 1'b0;
    end else begin
      cal_start <= 1'b0;
      if (wr_access && !pslverr && idx == IDX_CAL_SYNC) begin
        cal_sync_control_reg <= pwdata[7:0];
        cal_start <= cal_sync_control_reg[CAL_BIT] && !pwdata[CAL_BIT];
      end
    end
  end

  // busy from the start pulse until the done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_busy_q <= 1'b0;
    end else if (cal_start) begin
      cal_busy_q <= 1'b1;
    end else if (cal_done) begin
      cal_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event monitor: masked sticky latch, write one to clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_monitor_reg <= BYTE_RST;
      stable_q <= 1'b0;
    end else begin
      stable_q <= expired;
      for (int i = 0; i < 8; i++) begin
        if (wr_access && !pslverr && idx == IDX_IRQ_MON && pwdata[i]) begin
          irq_monitor_reg[i] <= 1'b0;
        end
      end
      // a new event wins over a clear in the same cycle
      if (cal_start && irq_mask_reg[ST_CAL_BIT]) begin
        irq_monitor_reg[ST_CAL_BIT] <= 1'b1;
      end
      if (expired && !stable_q && irq_mask_reg[ST_STABLE_BIT]) begin
        irq_monitor_reg[ST_STABLE_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // lock detector and stability timer
  // ----------------------------------------------------------------
  spc_lock_det u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .enable(!pll_config_reg[LD_DIS_BIT]),
    .sample_en(pfd_sample),
    .in_phase(pfd_in_phase),
    .run_sel(pll_config_reg[LD_DIV_LSB +: 2]),
    .locked(locked)
  );

  // enabled pll times from lock; disabled pll times from the disable
  assign arm_next = pll_enable_reg ? locked : 1'b1;

  // arming; any change of the enable restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_en_q <= 1'b0;
      arm_reg <= 1'b0;
    end else begin
      pll_en_q <= pll_enable_reg;
      arm_reg <= arm_next && (pll_en_q == pll_enable_reg);
    end
  end

  // a disabled detector never locks: software zeroes the setting
  spc_stab_timer #(
    .MS_CYC(MS_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .arm(arm_reg),
    .setting(stability_timer_setting_reg),
    .expired(expired)
  );

  // ----------------------------------------------------------------
  // analog-facing controls, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable <= 1'b0;
      cp_current <= PLL_CONFIG_RST[CP_CUR_LSB +: 3];
      ext_filter <= 1'b0;
      sys_period <= '0;
      cal_busy <= 1'b0;
      pll_locked <= 1'b0;
      sys_stable <= 1'b0;
      ref_mon_en <= 1'b0;
    end else begin
      pll_enable <= pll_enable_reg;
      if (pll_config_reg[CP_MAN_BIT]) begin
        cp_current <= pll_config_reg[CP_CUR_LSB +: 3];
      end else begin
        cp_current <= auto_cp(fb_div_n);
      end
      ext_filter <= pll_config_reg[EXT_LF_BIT];
      sys_period <= nominal_period_reg;
      cal_busy <= cal_busy_q;
      pll_locked <= locked;
      sys_stable <= expired;
      ref_mon_en <= expired;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_REF_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    ref_mon_en |-> $past(expired))
    else $error("reference monitors on before stable");
  AST_AUTO_CP: assert property (@(posedge pclk) disable iff (!presetn)
    !pll_config_reg[CP_MAN_BIT] |=> cp_current == auto_cp($past(fb_div_n)))
    else $error("auto pump current not from divider");
  AST_MAN_CP: assert property (@(posedge pclk) disable iff (!presetn)
    pll_config_reg[CP_MAN_BIT] |=>
      cp_current == $past(pll_config_reg[CP_CUR_LSB +: 3]))
    else $error("manual pump current not from field");
  AST_CAL_CLEAR_START: assert property (@(posedge pclk)
    disable iff (!presetn)
    cal_start |-> $past(cal_sync_control_reg[CAL_BIT])
      && !cal_sync_control_reg[CAL_BIT])
    else $error("calibration start without one-to-zero write");
  AST_CAL_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    cal_start |=> cal_busy_q ##1 cal_busy)
    else $error("calibration busy not raised by start");
  AST_STATUS_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup && !pwrite && idx == IDX_STATUS |=>
      prdata[ST_STABLE_BIT] == $past(expired))
    else $error("status bit 4 does not show expiry");
  AST_CAL_LATCH_MASK: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(irq_monitor_reg[ST_CAL_BIT]) |->
      $past(cal_start && irq_mask_reg[ST_CAL_BIT]))
    else $error("calibration event latched while masked");
endmodule
`default_nettype wire

// File: shared/spc_pkg.sv
// spc_pkg: register indices, field positions, reset values and timing
// constants for the system clock pll control block.
// assumes: 32-bit apb, byte registers sit in the low lane of one word.
package spc_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PLL_CONFIG = 14'h0100;
  localparam logic [13:0] IDX_PLL_ENABLE = 14'h0110;
  localparam logic [13:0] IDX_PERIOD_0 = 14'h0103;
  localparam logic [13:0] IDX_PERIOD_1 = 14'h0104;
  localparam logic [13:0] IDX_PERIOD_2 = 14'h0105;
  localparam logic [13:0] IDX_STAB_0 = 14'h0106;
  localparam logic [13:0] IDX_STAB_1 = 14'h0107;
  localparam logic [13:0] IDX_STAB_2 = 14'h0108;
  localparam logic [13:0] IDX_CAL_SYNC = 14'h0A02;
  localparam logic [13:0] IDX_STATUS = 14'h0D01;
  localparam logic [13:0] IDX_IRQ_MON = 14'h0D02;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0D03;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LD_DIV_LSB = 0;
  localparam int LD_DIS_BIT = 2;
  localparam int CP_CUR_LSB = 3;
  localparam int CP_MAN_BIT = 6;
  localparam int EXT_LF_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int ST_CAL_BIT = 1;
  localparam int ST_STABLE_BIT = 4;
  localparam int ST_LOCK_BIT = 0;
  localparam int PERIOD_W = 21;
  localparam int STAB_W = 20;
  localparam int LOCK_CNT_W = 11;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PLL_CONFIG_RST = 8'h18; // 4 pump steps, auto
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ----------------------------------------------------------------
  // lock run lengths selected by the divider field
  // ----------------------------------------------------------------
  localparam logic [LOCK_CNT_W-1:0] LOCK_RUN_0 = 11'h080; // 128
  localparam logic [LOCK_CNT_W-1:0] LOCK_RUN_1 = 11'h100; // 256
  localparam logic [LOCK_CNT_W-1:0] LOCK_RUN_2 = 11'h200; // 512
  localparam logic [LOCK_CNT_W-1:0] LOCK_RUN_3 = 11'h400; // 1024
  // ----------------------------------------------------------------
  // automatic pump current thresholds on the feedback divider
  // ----------------------------------------------------------------
  localparam logic [7:0] N_LOW = 8'h10;
  localparam logic [7:0] N_MID = 8'h40;
  localparam logic [2:0] CP_CODE_HI = 3'h7; // 8 steps
  localparam logic [2:0] CP_CODE_MID = 3'h3; // 4 steps
  localparam logic [2:0] CP_CODE_LO = 3'h1; // 2 steps
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S; // one millisecond
endpackage

// File: rtl/spc_lock_det.sv
// spc_lock_det: counts consecutive in-phase phase detector samples.
// assumes: sample_en is a one-cycle pulse per phase detector cycle.
`timescale 1ns/1ps
`default_nettype none
module spc_lock_det
  import spc_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic enable, // detector running
  input wire logic sample_en, // one phase detector decision
  input wire logic in_phase, // decision is in phase
  input wire logic [1:0] run_sel, // required run length select
  output logic locked // lock declared
);
  logic [LOCK_CNT_W-1:0] run_reg;
  logic [LOCK_CNT_W-1:0] target;

  // required run length from the select field
  always_comb begin
    unique case (run_sel)
      2'h0: target = LOCK_RUN_0;
      2'h1: target = LOCK_RUN_1;
      2'h2: target = LOCK_RUN_2;
      2'h3: target = LOCK_RUN_3;
    endcase
  end

  // run counter: any out-of-phase sample restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= '0;
      locked <= 1'b0;
    end else if (!enable) begin
      run_reg <= '0;
      locked <= 1'b0;
    end else if (sample_en) begin
      if (!in_phase) begin
        run_reg <= '0;
        locked <= 1'b0;
      end else if (!locked) begin
        run_reg <= run_reg + 1'b1;
        if (run_reg + 1'b1 >= target) begin
          locked <= 1'b1;
        end
      end
    end
  end

  AST_OOP_DROPS_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    enable && sample_en && !in_phase |=> !locked)
    else $error("lock held after out-of-phase sample");
  AST_LOCK_NEEDS_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(locked) |-> $past(run_reg) + 1'b1 >= $past(target))
    else $error("lock declared before required run");
  AST_DISABLED_NO_LOCK: assert property (@(posedge pclk)
    disable iff (!presetn) !enable |=> !locked)
    else $error("lock declared while detector disabled");
endmodule
`default_nettype wire

// File: rtl/spc_stab_timer.sv
// spc_stab_timer: millisecond stability timer with zero meaning done.
// assumes: arm is a level; clearing it restarts the count.
`timescale 1ns/1ps
`default_nettype none
module spc_stab_timer
  import spc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES // clock cycles per millisecond
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic arm, // timing allowed
  input wire logic [STAB_W-1:0] setting, // milliseconds
  output logic expired // timer has run out
);
  logic [31:0] div_reg;
  logic [STAB_W-1:0] ms_reg;
  logic tick;

  assign tick = (div_reg == 32'(MS_CYC - 1));

  // millisecond divider, aligned to the start of timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (!arm || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  // elapsed milliseconds and expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_reg <= '0;
      expired <= 1'b0;
    end else if (setting == '0) begin
      ms_reg <= '0;
      expired <= 1'b1;
    end else if (!arm) begin
      ms_reg <= '0;
      expired <= 1'b0;
    end else if (tick && !expired) begin
      ms_reg <= ms_reg + 1'b1;
      expired <= (ms_reg + 1'b1 >= setting);
    end
  end

  AST_ZERO_EXPIRES: assert property (@(posedge pclk) disable iff (!presetn)
    setting == '0 |=> expired)
    else $error("zero setting did not expire timer");
  AST_UNARMED_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !arm && setting != '0 |=> !expired)
    else $error("timer expired while not armed");
endmodule
`default_nettype wire

// File: tb/tb_sys_ref_clock_pll_control.sv
// tb_sys_ref_clock_pll_control: self-checking bench for spc_sys_ref_clock_ctrl.
// assumes: apb slave answers in one access cycle; MS_CYC shortened to 10.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
  end \
end
module tb_sys_ref_clock_pll_control
  import spc_pkg::*;
;
  localparam int MSC = 10;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
  logic pfd_sample, pfd_in_phase, cal_done, pll_enable, ext_filter;
  logic cal_start, cal_busy, pll_locked, sys_stable, ref_mon_en;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] fb_div_n;
  logic [2:0] cp_current;
  logic [PERIOD_W-1:0] sys_period;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  spc_sys_ref_clock_ctrl #(.MS_CYC(MSC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pfd_sample(pfd_sample), .pfd_in_phase(pfd_in_phase),
    .fb_div_n(fb_div_n), .cal_done(cal_done), .pll_enable(pll_enable),
    .cp_current(cp_current), .ext_filter(ext_filter),
    .sys_period(sys_period), .cal_start(cal_start), .cal_busy(cal_busy),
    .pll_locked(pll_locked), .sys_stable(sys_stable),
    .ref_mon_en(ref_mon_en));

  // ------------------------------------------------------------------
  // clock, hang guard and verdict
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [13:0] idx, input logic w,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, {24'h000000, d});
  endtask

  // phase detector decisions, one pulse every other cycle
  task automatic feed(input int cnt, input logic ph);
    repeat (cnt) begin
      @(posedge pclk);
      pfd_sample <= 1'b1;
      pfd_in_phase <= ph;
      @(posedge pclk);
      pfd_sample <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask

  // count cycles until sys_stable shows the wanted level
  task automatic wait_stab(input logic lvl, input int lim);
    n = 0;
    while (sys_stable !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    apb(IDX_PLL_CONFIG, 1'b0, 32'h0);
    `CHK("cfg_rst", 32'h00000018, rd)
    `CHK("cp_field_rst", 3'h3, rd[CP_CUR_LSB +: 3])
    `CHK("cp_rst", CP_CODE_HI, cp_current)
    `CHK("filt_rst", 1'b0, ext_filter)
    apb(14'h0200, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(IDX_STATUS, 1'b0, 32'h0);
    `CHK("stab_zero", 1'b1, rd[ST_STABLE_BIT])
    `CHK("mon_zero", 1'b1, ref_mon_en)
  endtask

  task automatic t_pump();
    logic [7:0] nv[3] = '{8'h08, 8'h20, 8'h64};
    logic [2:0] cv[3] = '{3'h7, 3'h3, 3'h1};
    wr(IDX_PLL_CONFIG, 8'h28);
    for (int i = 0; i < 3; i++) begin
      fb_div_n <= nv[i];
      repeat (3) @(posedge pclk);
      `CHK("cp_auto", cv[i], cp_current)
    end
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PLL_CONFIG, 8'h40 | 8'(c << 3));
      repeat (2) @(posedge pclk);
      `CHK("cp_manual", 3'(c), cp_current)
    end
    wr(IDX_PLL_CONFIG, 8'h98);
    repeat (2) @(posedge pclk);
    `CHK("filt_ext", 1'b1, ext_filter)
  endtask

  task automatic t_period();
    wr(IDX_PERIOD_0, 8'hA5);
    wr(IDX_PERIOD_1, 8'h5A);
    wr(IDX_PERIOD_2, 8'hFF);
    apb(IDX_PERIOD_2, 1'b0, 32'h0);
    `CHK("period_rd", 32'h0000001F, rd)
    `CHK("period_out", 21'h1F5AA5, sys_period)
  endtask

  task automatic t_lock();
    for (int s = 0; s < 4; s++) begin
      wr(IDX_PLL_CONFIG, 8'h18 | 8'(s));
      feed(64, 1'b1);
      feed(1, 1'b0);
      feed((128 << s) - 1, 1'b1);
      `CHK("lock_short", 1'b0, pll_locked)
      feed(1, 1'b1);
      `CHK("lock_run", 1'b1, pll_locked)
      feed(1, 1'b0);
      `CHK("lock_miss", 1'b0, pll_locked)
    end
    wr(IDX_PLL_CONFIG, 8'h1C);
    wr(IDX_STAB_0, 8'h00);
    feed(200, 1'b1);
    `CHK("lock_off", 1'b0, pll_locked)
    wr(IDX_PLL_CONFIG, 8'h18);
    feed(1, 1'b0);
  endtask

  task automatic t_timer();
    wr(IDX_STAB_0, 8'h02);
    wr(IDX_PLL_ENABLE, 8'h01);
    repeat (60) @(posedge pclk);
    `CHK("pll_en", 1'b1, pll_enable)
    `CHK("stab_no_lock", 1'b0, sys_stable)
    `CHK("mon_idle", 1'b0, ref_mon_en)
    feed(128, 1'b1);
    wait_stab(1'b1, 60);
    `CHK("stab_from_lock", 1'b1, n >= 17 && n <= 30)
    apb(IDX_STATUS, 1'b0, 32'h0);
    `CHK("stat_stable", 1'b1, rd[ST_STABLE_BIT])
    `CHK("mon_on", 1'b1, ref_mon_en)
    wr(IDX_PLL_ENABLE, 8'h00);
    wait_stab(1'b0, 8);
    `CHK("stab_restart", 1'b0, sys_stable)
    wait_stab(1'b1, 60);
    `CHK("stab_from_dis", 1'b1, n >= 17 && n <= 30)
  endtask

  task automatic t_cal(input logic [7:0] mask);
    wr(IDX_IRQ_MASK, mask);
    wr(IDX_IRQ_MON, 8'hFF);
    wr(IDX_CAL_SYNC, 8'h01);
    `CHK("cal_on_set", 1'b0, cal_busy)
    wr(IDX_CAL_SYNC, 8'h00);
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      if (cal_start === 1'b1)
        seen = 1'b1;
    end
    `CHK("cal_start", 1'b1, seen)
    `CHK("cal_busy_on", 1'b1, cal_busy)
    apb(IDX_STATUS, 1'b0, 32'h0);
    `CHK("cal_stat", 1'b1, rd[ST_CAL_BIT])
    apb(IDX_IRQ_MON, 1'b0, 32'h0);
    `CHK("cal_irq", mask[1], rd[1])
    @(posedge pclk);
    cal_done <= 1'b1;
    @(posedge pclk);
    cal_done <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("cal_done", 1'b0, cal_busy)
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pfd_sample = 1'b0;
    pfd_in_phase = 1'b0;
    fb_div_n = 8'h08;
    cal_done = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_pump();
    t_period();
    t_lock();
    t_timer();
    t_cal(8'h02);
    t_cal(8'h00);
    summarize();
  end
endmodule
`default_nettype wire
